// ---- rtl/iadc_pkg.sv ----
// package: constants and types for the incremental converter sequencer
// Summary of operation
// - integrator reset asserted at the start of every conversion
// - result counter increments each integration clock with comparator high
// - feedback reference follows comparator to drive integrator back toward zero
// - integrate over 2^(n+2) integration clocks per result
// - period timer counts 256 clocks and pulses a period tick
// - 2^(n-6) integrating periods then one period for reset and processing
// - resolution n from 6 through 14 sizes counter and timing
// - result delivered unsigned or two's complement per format setting
// - data-available flag set on new result, cleared by software after read
package iadc_pkg;
  localparam int unsigned PERIOD_COUNT = 256;
  localparam int unsigned PERIOD_BITS = 8;
  // window is 256 * 2^(n-6) = 2^(n+2) clocks; count is scaled back to n bits
  localparam int unsigned EVAL_SHIFT = 2;
  localparam int unsigned RES_MIN = 6;
  localparam int unsigned RES_MAX = 14;
  localparam int unsigned RES_BITS = 4;
  localparam logic [3:0] RES_RESET = 4'h8;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned FIFO_WIDTH = 16;
  localparam int unsigned SYS_CLK_HZ = 25000000;
  localparam int unsigned RATE_MIN_SPS = 125;
  localparam int unsigned RATE_MAX_SPS = 31250;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_INTEG = 3'b010,
    ST_PROC = 3'b100
  } iadc_state_t;

  // signed result: offset by half scale, i.e. invert msb of the n-bit count
  function automatic logic [15:0] iadc_format(input logic [15:0] count,
      input logic [3:0] res, input logic signed_fmt);
    logic [15:0] v;
    logic [15:0] half;
    v = count;
    half = 16'h0001 << res;
    half = half >> 1;
    if (signed_fmt) begin
      v = count - half;
      if (v[res - 4'h1]) begin
        v = v | ~((16'h0001 << res) - 16'h0001);
      end
    end
    return v;
  endfunction
endpackage

// ---- rtl/iadc_fifo.sv ----
// module: result fifo with valid/ready on both sides
`timescale 1ns/1ps
module iadc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // write side
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  // read side
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("depth must be power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr_reg;
  logic [AW:0] rptr_reg;
  logic [WIDTH-1:0] out_reg;
  logic out_valid_reg;
  logic empty;
  logic pop;

  assign empty = (wptr_reg == rptr_reg);
  assign wr_ready = !((wptr_reg[AW] != rptr_reg[AW]) && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]));
  // output register refills whenever the fifo holds a word and the register is empty or being taken
  assign pop = !empty && (!out_valid_reg || rd_ready);
  assign rd_valid = out_valid_reg;
  assign rd_data = out_reg;

  always_ff @(posedge sys_clk) begin
    if (wr_valid && wr_ready) begin
      mem[wptr_reg[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wptr_reg <= '0;
    end else if (wr_valid && wr_ready) begin
      wptr_reg <= wptr_reg + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rptr_reg <= '0;
      out_reg <= '0;
      out_valid_reg <= 1'b0;
    end else begin
      if (pop) begin
        rptr_reg <= rptr_reg + 1'b1;
        out_reg <= mem[rptr_reg[AW-1:0]];
        out_valid_reg <= 1'b1;
      end else if (rd_ready) begin
        out_valid_reg <= 1'b0;
      end
    end
  end
endmodule // iadc_fifo

// ---- rtl/iadc_seq.sv ----
// module: incremental converter sequencer top
`timescale 1ns/1ps
module iadc_seq
  import iadc_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset; sys_clk is the integration clock
  input wire logic sys_clk,
  input wire logic reset,
  // configuration
  input wire logic run,
  input wire logic [3:0] resolution,
  input wire logic signed_format,
  // analog side
  input wire logic comparator,
  output logic integ_reset,
  output logic ref_positive,
  output logic period_tick,
  // result stream
  output logic result_valid,
  input wire logic result_ready,
  output logic [15:0] result_data,
  // data-available flag
  output logic data_available,
  input wire logic clear_flag
);
  initial begin
    if (DEPTH < 2) $error("fifo depth too small");
  end

  ////////////////////////////////////////////////////////////////
  logic comp_meta_reg;
  logic comp_sync_reg;
  iadc_state_t state_reg;
  logic [PERIOD_BITS-1:0] timer_reg;
  logic [8:0] period_cnt_reg;
  logic [16:0] count_reg;
  logic [16:0] count_final;
  logic [16:0] count_scaled;
  logic [3:0] res_reg;
  logic fmt_reg;
  logic push_reg;
  logic [15:0] push_data_reg;
  logic ref_pos_reg;
  logic flag_reg;
  logic fifo_ready;
  logic [8:0] periods_needed;
  logic [3:0] res_ok;

  // out-of-range settings clamp into the served range
  assign res_ok = (resolution < 4'(RES_MIN)) ? 4'(RES_MIN) :
                  (resolution > 4'(RES_MAX)) ? 4'(RES_MAX) : resolution;
  assign periods_needed = 9'h001 << (res_reg - 4'(RES_MIN));

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      comp_meta_reg <= 1'b0;
      comp_sync_reg <= 1'b0;
    end else begin
      comp_meta_reg <= comparator;
      comp_sync_reg <= comp_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////
  // period timer, runs on the integration clock whenever not idle
  always_ff @(posedge sys_clk) begin
    if (reset || state_reg == ST_IDLE) begin
      timer_reg <= '0;
    end else begin
      timer_reg <= timer_reg + 1'b1;
    end
  end
  assign period_tick = (state_reg != ST_IDLE) &&
                       (timer_reg == PERIOD_BITS'(PERIOD_COUNT - 1));

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      period_cnt_reg <= '0;
      res_reg <= RES_RESET;
      fmt_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (run) begin
            res_reg <= res_ok;
            fmt_reg <= signed_format;
            state_reg <= ST_PROC;
          end
        end
        ST_INTEG: begin
          if (period_tick) begin
            if (period_cnt_reg == periods_needed - 9'h001) begin
              period_cnt_reg <= '0;
              state_reg <= ST_PROC;
            end else begin
              period_cnt_reg <= period_cnt_reg + 9'h001;
            end
          end
        end
        ST_PROC: begin
          // stall here while the fifo is full, so no result is lost
          if (period_tick && fifo_ready) begin
            if (run) begin
              res_reg <= res_ok;
              fmt_reg <= signed_format;
              state_reg <= ST_INTEG;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // integrator held in reset during the processing period
  assign integ_reset = (state_reg != ST_INTEG);

  always_ff @(posedge sys_clk) begin
    if (reset || state_reg != ST_INTEG) begin
      count_reg <= '0;
    end else if (comp_sync_reg) begin
      count_reg <= count_reg + 17'h00001;
    end
  end
  // 17 bits: a full 14-bit window reaches 2^16 counts
  assign count_final = count_reg + {16'h0000, comp_sync_reg};
  assign count_scaled = count_final >> EVAL_SHIFT;

  always_ff @(posedge sys_clk) begin
    if (reset || state_reg != ST_INTEG) begin
      ref_pos_reg <= 1'b0;
    end else begin
      ref_pos_reg <= !comp_sync_reg;
    end
  end
  assign ref_positive = ref_pos_reg;

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      push_reg <= 1'b0;
      push_data_reg <= '0;
    end else begin
      if (state_reg == ST_INTEG && period_tick &&
          period_cnt_reg == periods_needed - 9'h001) begin
        // includes this last cycle's sample; full scale saturates at 2^n - 1
        push_reg <= 1'b1;
        push_data_reg <= iadc_format((count_scaled[15:0] == (16'h0001 << res_reg)) ?
          count_scaled[15:0] - 16'h0001 : count_scaled[15:0], res_reg, fmt_reg);
      end else if (fifo_ready) begin
        push_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flag_reg <= 1'b0;
    end else if (push_reg && fifo_ready) begin
      flag_reg <= 1'b1;
    end else if (clear_flag) begin
      flag_reg <= 1'b0;
    end
  end
  assign data_available = flag_reg;

  iadc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .wr_valid(push_reg),
    .wr_ready(fifo_ready),
    .wr_data(push_data_reg),
    .rd_valid(result_valid),
    .rd_ready(result_ready),
    .rd_data(result_data)
  );

  ////////////////////////////////////////////////////////////////
  logic [8:0] tick_seen_reg;
  always_ff @(posedge sys_clk) begin
    if (reset || state_reg != ST_INTEG) begin
      tick_seen_reg <= '0;
    end else if (period_tick) begin
      tick_seen_reg <= tick_seen_reg + 9'h001;
    end
  end

  tick_period_a: assert property (@(posedge sys_clk) disable iff (reset)
    period_tick |=> !period_tick [*8]) else $error("period tick too close");
  integ_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    integ_reset |=> count_reg == 17'h00000) else $error("count not cleared");
  count_inc_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state_reg == ST_INTEG && $past(state_reg) == ST_INTEG && $past(comp_sync_reg))
    |-> count_reg == $past(count_reg) + 17'h00001) else $error("count missed");
  ref_follow_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state_reg == ST_INTEG && comp_sync_reg) |=> (!ref_positive || integ_reset))
    else $error("reference not reversed");
  start_reset_a: assert property (@(posedge sys_clk) disable iff (reset)
    ($rose(state_reg == ST_INTEG)) |-> $past(integ_reset))
    else $error("no integrator reset");
  window_len_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state_reg == ST_INTEG) |-> tick_seen_reg < periods_needed)
    else $error("integration overrun");
  flag_set_a: assert property (@(posedge sys_clk) disable iff (reset)
    (push_reg && fifo_ready) |=> data_available) else $error("flag not set");
  res_range_a: assert property (@(posedge sys_clk) disable iff (reset)
    res_reg >= 4'(RES_MIN) && res_reg <= 4'(RES_MAX)) else $error("bad resolution");
  proc_len_a: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(state_reg == ST_PROC) && fifo_ready |=> (state_reg == ST_PROC) [*8])
    else $error("processing period short");
endmodule // iadc_seq

// ---- bench/iadc_analog_model.sv ----
// behavioural integrator and comparator facing the sequencer
`timescale 1ns/1ps
module iadc_analog_model (
  // same clock as the digital section
  input wire logic sys_clk,
  // sequencer side
  input wire logic integ_reset,
  input wire logic ref_positive,
  output logic comparator,
  // input level in 256ths of full scale
  input wire logic [8:0] level
);
  logic signed [11:0] acc_reg;
  always_ff @(posedge sys_clk) begin
    if (integ_reset) begin
      acc_reg <= 12'sh000;
    end else begin
      acc_reg <= acc_reg + 12'(level) - (ref_positive ? 12'sh000 : 12'sh100);
    end
  end
  // signed so that an overshoot below zero does not wrap to full scale
  assign comparator = acc_reg >= 12'sh100;
endmodule // iadc_analog_model

// ---- bench/tb_incremental_adc_sequencer.sv ----
// self-checking bench for the incremental converter sequencer
`timescale 1ns/1ps
module tb_incremental_adc_sequencer;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic run = 1'b0;
  logic [3:0] resolution = 4'h8;
  logic signed_format = 1'b0;
  logic comparator;
  logic integ_reset;
  logic ref_positive;
  logic period_tick;
  logic result_valid;
  logic result_ready = 1'b0;
  logic [15:0] result_data;
  logic data_available;
  logic clear_flag = 1'b0;
  logic [8:0] level = 9'h000;
  logic [15:0] d;
  int fails = 0;
  int n_checks = 0;
  // small fifo so that the fill test stays short
  iadc_seq #(.DEPTH(4)) uut (.sys_clk(sys_clk), .reset(reset), .run(run),
    .resolution(resolution), .signed_format(signed_format), .comparator(comparator),
    .integ_reset(integ_reset), .ref_positive(ref_positive), .period_tick(period_tick),
    .result_valid(result_valid), .result_ready(result_ready), .result_data(result_data),
    .data_available(data_available), .clear_flag(clear_flag));
  iadc_analog_model model (.sys_clk(sys_clk), .integ_reset(integ_reset),
    .ref_positive(ref_positive), .comparator(comparator), .level(level));
  // runs at the rated 25 MHz integration clock (SYS_CLK_HZ); only cycle counts are judged
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic step;
    @(negedge sys_clk);
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got,
      input int tol);
    logic signed [15:0] dif;
    dif = got - exp;
    n_checks++;
    if ((^got === 1'bx) || dif > tol || dif < -tol) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report;
    if (fails == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic start(input logic [3:0] res, input logic fmt, input logic [8:0] lvl);
    step;
    reset = 1'b1;
    run = 1'b0;
    resolution = res;
    signed_format = fmt;
    level = lvl;
    repeat (4) step;
    chk("integ_reset", 16'h1, 16'(integ_reset), 0);
    chk("result_valid", 16'h0, 16'(result_valid), 0);
    chk("data_available", 16'h0, 16'(data_available), 0);
    reset = 1'b0;
    run = 1'b1;
  endtask
  task automatic span(input logic v, output int n);
    n = 0;
    while (integ_reset === v && n < 9000) begin
      n++;
      step;
    end
  endtask
  // ready held until the falling edge after valid is seen: exactly one word taken
  task automatic get_res;
    int i;
    result_ready = 1'b1;
    for (i = 0; i < 9000 && result_valid !== 1'b1; i++) step;
    d = result_data;
    step;
    result_ready = 1'b0;
  endtask
  task automatic t_timing(input logic [3:0] res, input int n);
    int k;
    int lo;
    int hi;
    start(res, 1'b0, 9'h000);
    span(1'b1, k);
    span(1'b0, lo);
    span(1'b1, hi);
    chk("integ window", 16'(256 << (n - 6)), 16'(lo), 0);
    chk("reset period", 16'h0100, 16'(hi), 0);
    for (k = 0; k < 999 && period_tick !== 1'b1; k++) step;
    step;
    for (k = 1; k < 999 && period_tick !== 1'b1; k++) step;
    chk("tick gap", 16'h0100, 16'(k), 0);
  endtask
  task automatic t_result(input logic [3:0] res, input logic fmt, input logic [8:0] lvl,
      input logic [15:0] exp, input int tol);
    start(res, fmt, lvl);
    get_res;
    chk("result", exp, d, tol);
  endtask
  task automatic t_ref(input logic [8:0] lvl, input logic exp);
    int k;
    start(4'h6, 1'b0, lvl);
    span(1'b1, k);
    repeat (20) step;
    chk("ref_positive", 16'(exp), 16'(ref_positive), 0);
  endtask
  task automatic t_flag;
    start(4'h6, 1'b0, 9'h080);
    get_res;
    chk("data_available", 16'h1, 16'(data_available), 0);
    clear_flag = 1'b1;
    step;
    clear_flag = 1'b0;
    chk("data_available", 16'h0, 16'(data_available), 0);
    level = 9'h000;
    get_res;
    chk("cleared count", 16'h0000, d, 0);
  endtask
  task automatic t_fifo;
    int k;
    int got;
    start(4'h6, 1'b0, 9'h000);
    repeat (3584) step;
    got = 0;
    for (k = 0; k < 300; k++) begin
      got += (integ_reset !== 1'b1);
      step;
    end
    chk("stalled", 16'h0, 16'(got), 0);
    run = 1'b0;
    result_ready = 1'b1;
    got = 0;
    for (k = 0; k < 1500; k++) begin
      if (result_valid === 1'b1) begin
        got++;
        k = 0;
      end
      step;
    end
    result_ready = 1'b0;
    chk("words", 16'h6, 16'(got), 2);
  endtask
  initial begin
    #(60000 * 40);
    fails++;
    final_report;
  end
  initial begin
    t_timing(4'h3, 6);
    t_timing(4'h8, 8);
    t_result(4'h8, 1'b0, 9'h000, 16'h0000, 0);
    t_result(4'h8, 1'b1, 9'h000, 16'hFF80, 0);
    t_result(4'h8, 1'b0, 9'h080, 16'h0080, 8);
    t_result(4'h8, 1'b1, 9'h080, 16'h0000, 8);
    t_result(4'h6, 1'b0, 9'h100, 16'h003F, 4);
    t_result(4'hA, 1'b0, 9'h040, 16'h0100, 8);
    t_ref(9'h000, 1'b1);
    t_ref(9'h100, 1'b0);
    t_flag;
    t_fifo;
    final_report;
  end
endmodule // tb_incremental_adc_sequencer
